// ==== rtl/wireless_hotspot_enable_ctrl.sv ====
`timescale 1ns/1ps
`include "hotspot_ctrl_map.svh"
module wireless_hotspot_enable_ctrl #(
	parameter longint unsigned STARTUP_CYCLES = `HS_STARTUP_MAX_S * `HS_CLK_HZ,
	parameter longint unsigned IDLE_CYCLES    = `HS_IDLE_MIN * 60 * `HS_CLK_HZ,
	parameter logic [31:0]     SERIAL_NUMBER  = 32'h00000001, // Arbitrary value
	parameter logic [31:0]     DEFAULT_PASS   = 32'h00000000  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst_b,
	// Enable sources
	input  wire logic                         reedClosed,
	input  wire hotspot_ctrl_pkg::reg_write_t regWrite,
	input  wire logic                         sdi12HotspotEnableCommand,
	input  wire logic                         powerOnEnableOption,
	// Wireless client side
	input  wire hotspot_ctrl_pkg::client_req_t client,
	// Outputs
	output logic                              beep,
	output logic                              radioEnable,
	output logic                              hotspotAvailable,
	output logic [15:0]                       enableRegRead,
	output logic [`HS_SERIAL_WIDTH-1:0]       networkId,
	output logic                              accessGrant,
	output logic                              paramWriteGrant,
	output logic                              accessRefused
);
	// ==========================================
	// Enable request gathering
	logic                         powerUpPending;
	logic                         reedPrev;
	logic                         enableReq;
	logic                         connPrev;
	logic [39:0]                  timer;
	logic [31:0]                  password;
	logic [31:0]                  keyword;
	logic                         keywordSet;
	hotspot_ctrl_pkg::hs_state_t  state;

	function automatic logic isEnableWrite(input hotspot_ctrl_pkg::reg_write_t w);
		return w.wr && (w.addr == `HS_ENABLE_REG_ADDR) && (w.data == `HS_ENABLE_VALUE);
	endfunction : isEnableWrite

	// Wide enough for minutes at the full clock rate
	function automatic logic reached(input logic [39:0] t, input longint unsigned last);
		return {24'h000000, t} >= last;
	endfunction : reached

	// Power-up request caught once, after reset release
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			powerUpPending <= 1'b1;
		end else begin
			powerUpPending <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reedPrev <= 1'b0;
		end else begin
			reedPrev <= reedClosed;
		end
	end

	always_comb begin
		enableReq = (reedClosed && !reedPrev)
			|| isEnableWrite(regWrite)
			|| sdi12HotspotEnableCommand
			|| (powerUpPending && powerOnEnableOption);
	end

	// Register keeps the last written value for readback
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			enableRegRead <= `HS_ENABLE_REG_RESET;
		end else if (regWrite.wr && regWrite.addr == `HS_ENABLE_REG_ADDR) begin
			enableRegRead <= regWrite.data;
		end
	end

	// ==========================================
	// Hotspot state and timers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			connPrev <= 1'b0;
		end else begin
			connPrev <= client.connected;
		end
	end

	// One counter runs from the request through start-up into idle;
	// idle must exceed start-up, as no client can join before it is up
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state <= hotspot_ctrl_pkg::HS_OFF;
			timer <= '0;
		end else if (enableReq) begin
			state <= (state == hotspot_ctrl_pkg::HS_RUNNING) ? hotspot_ctrl_pkg::HS_RUNNING
				: hotspot_ctrl_pkg::HS_STARTING;
			timer <= '0;
		end else begin
			case (state)
				hotspot_ctrl_pkg::HS_OFF: begin
					timer <= '0;
				end
				hotspot_ctrl_pkg::HS_STARTING: begin
					// Two short: state and available flag each lag by a flop
					timer <= timer + 40'h0000000001;
					if (reached(timer, STARTUP_CYCLES - 2)) begin
						state <= hotspot_ctrl_pkg::HS_RUNNING;
					end
				end
				hotspot_ctrl_pkg::HS_RUNNING: begin
					if (client.connected) begin
						timer <= '0;
					end else if (connPrev) begin
						timer <= '0;
					end else if (reached(timer, IDLE_CYCLES - 1)) begin
						state <= hotspot_ctrl_pkg::HS_OFF;
						timer <= '0;
					end else begin
						timer <= timer + 40'h0000000001;
					end
				end
				default: begin
					state <= hotspot_ctrl_pkg::HS_OFF;
					timer <= '0;
				end
			endcase
		end
	end

	// Beep only when start-up actually begins, not on re-requests while running
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			beep <= 1'b0;
		end else begin
			beep <= enableReq && (state != hotspot_ctrl_pkg::HS_RUNNING);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			radioEnable <= 1'b0;
		end else begin
			radioEnable <= (state != hotspot_ctrl_pkg::HS_OFF);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hotspotAvailable <= 1'b0;
		end else begin
			hotspotAvailable <= (state == hotspot_ctrl_pkg::HS_RUNNING);
		end
	end

	// Serial number doubles as the advertised network name
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			networkId <= SERIAL_NUMBER;
		end else begin
			networkId <= SERIAL_NUMBER;
		end
	end

	// ==========================================
	// Client access control
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			password <= DEFAULT_PASS;
		end else if (client.pwChange && client.authOk && client.connected) begin
			password <= client.value;
		end
	end

	// Keyword is volatile here; persistent storage lives outside
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			keyword    <= 32'h00000000;
			keywordSet <= 1'b0;
		end else if (client.keyChange && client.authOk && client.connected) begin
			keyword    <= client.value;
			keywordSet <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			accessGrant <= 1'b0;
		end else begin
			accessGrant <= client.accessReq && client.authOk && hotspotAvailable;
		end
	end

	// A wrong keyword is silently ignored rather than flagged
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			paramWriteGrant <= 1'b0;
		end else begin
			paramWriteGrant <= client.paramWrite && client.authOk && hotspotAvailable
				&& (!keywordSet || client.value == keyword);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			accessRefused <= 1'b0;
		end else begin
			accessRefused <= (client.accessReq || client.paramWrite)
				&& !(client.authOk && hotspotAvailable);
		end
	end

	// Password held for the external authenticator; compared outside
	logic unusedPw;
	assign unusedPw = ^password;
endmodule : wireless_hotspot_enable_ctrl

// ==== rtl/hotspot_ctrl_map.svh ====
`ifndef HOTSPOT_CTRL_MAP_SVH
`define HOTSPOT_CTRL_MAP_SVH
// Holding register index of the enable request
`define HS_ENABLE_REG_ADDR   16'h0191
`define HS_ENABLE_VALUE      16'h0001
`define HS_ENABLE_REG_RESET  16'h0000
// Timing in its own unit
`define HS_STARTUP_MAX_S     60
`define HS_IDLE_MIN          5
// 64 bits wide so the minute and second products do not wrap
`define HS_CLK_HZ            64'h0000000007735940
`define HS_SERIAL_WIDTH      32
`endif

// ==== rtl/hotspot_ctrl_pkg.sv ====
package hotspot_ctrl_pkg;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		HS_OFF      = 2'b00,
		HS_STARTING = 2'b01,
		HS_RUNNING  = 2'b11
	} hs_state_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] data;
	} reg_write_t;

	typedef struct packed {
		logic connected;
		logic authOk;
		logic accessReq;
		logic pwChange;
		logic keyChange;
		logic paramWrite;
		logic [31:0] value;
	} client_req_t;
endpackage : hotspot_ctrl_pkg

// ==== tb/hs_ctrl_assertions.sv ====
`timescale 1ns/1ps
module hs_ctrl_assertions #(
	parameter longint unsigned STARTUP_CYCLES = 20,
	parameter longint unsigned IDLE_CYCLES    = 50
) (
	// Watched ports
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	input wire hotspot_ctrl_pkg::reg_write_t  regWrite,
	input wire logic                          sdi12HotspotEnableCommand,
	input wire hotspot_ctrl_pkg::client_req_t client,
	input wire logic                          beep,
	input wire logic                          radioEnable,
	input wire logic                          hotspotAvailable,
	input wire logic                          accessRefused
);
	// ==========================================
	// Checks
	// Available no later than the start-up count after the beep
	localparam int StartMax = int'(STARTUP_CYCLES);
	localparam int IdleMax  = int'(IDLE_CYCLES) + 3;
	localparam int IdleMin  = int'(IDLE_CYCLES) - 2;
	logic wrOne;
	int   idle;
	assign wrOne = regWrite.wr && regWrite.addr == 16'h0191 && regWrite.data == 16'h0001;
	// Slack of a few cycles: the pipeline offset of the timer is not pinned down
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !radioEnable || client.connected || wrOne || sdi12HotspotEnableCommand) begin
			idle <= 0;
		end else begin
			idle <= idle + 1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_write_beep: assert property (!radioEnable && !beep && wrOne |=> beep)
		else $error("write gave no beep");
	a_cmd_beep: assert property (!radioEnable && !beep && sdi12HotspotEnableCommand |=> beep)
		else $error("command gave no beep");
	a_beep_radio: assert property (beep |=> radioEnable && !beep)
		else $error("beep not followed by radio on");
	a_start_bound: assert property (beep |-> ##[1:StartMax] hotspotAvailable)
		else $error("hotspot late");
	a_keep_conn: assert property (radioEnable && client.connected |=> radioEnable)
		else $error("radio off while connected");
	a_idle_max: assert property (radioEnable |-> idle <= IdleMax)
		else $error("radio on past idle limit");
	a_idle_min: assert property ($fell(radioEnable) && $past(rst_b) |-> idle >= IdleMin)
		else $error("radio off too early");
	a_refuse: assert property (client.accessReq && !client.authOk |=> accessRefused)
		else $error("access not refused");
	c_beep: cover property (beep);
	c_off: cover property ($fell(radioEnable));
	c_refuse: cover property (accessRefused);
endmodule : hs_ctrl_assertions

bind wireless_hotspot_enable_ctrl hs_ctrl_assertions #(
	.STARTUP_CYCLES(STARTUP_CYCLES),
	.IDLE_CYCLES   (IDLE_CYCLES)
) hs_ctrl_assertions_i (
	.ref_clk                  (ref_clk),
	.rst_b                    (rst_b),
	.regWrite                 (regWrite),
	.sdi12HotspotEnableCommand(sdi12HotspotEnableCommand),
	.client                   (client),
	.beep                     (beep),
	.radioEnable              (radioEnable),
	.hotspotAvailable         (hotspotAvailable),
	.accessRefused            (accessRefused)
);

// ==== tb/wireless_hotspot_enable_ctrl_tb.sv ====
`timescale 1ns/1ps
module wireless_hotspot_enable_ctrl_tb;
	// ==========================================
	// Bench
	localparam int Start = 20;
	localparam int Idle  = 50;
	logic ref_clk, rst_b, reedClosed, sdi12HotspotEnableCommand, powerOnEnableOption;
	logic beep, radioEnable, hotspotAvailable, accessGrant, paramWriteGrant, accessRefused;
	hotspot_ctrl_pkg::reg_write_t  regWrite;
	hotspot_ctrl_pkg::client_req_t client;
	logic [15:0]                   enableRegRead;
	logic [31:0]                   networkId;
	int                            miscompares;
	int                            cmp_count;
	wireless_hotspot_enable_ctrl #(
		.STARTUP_CYCLES(Start),
		.IDLE_CYCLES   (Idle),
		.SERIAL_NUMBER (32'h0000abcd) // Arbitrary value
	) wireless_hotspot_enable_ctrl_i (
		.ref_clk                  (ref_clk),
		.rst_b                    (rst_b),
		.reedClosed               (reedClosed),
		.regWrite                 (regWrite),
		.sdi12HotspotEnableCommand(sdi12HotspotEnableCommand),
		.powerOnEnableOption      (powerOnEnableOption),
		.client                   (client),
		.beep                     (beep),
		.radioEnable              (radioEnable),
		.hotspotAvailable         (hotspotAvailable),
		.enableRegRead            (enableRegRead),
		.networkId                (networkId),
		.accessGrant              (accessGrant),
		.paramWriteGrant          (paramWriteGrant),
		.accessRefused            (accessRefused)
	);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_cy(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cy
	// One request per call; returns just after the edge that answers it
	task automatic fire(input int src, input logic [15:0] d);
		@(posedge ref_clk);
		case (src)
			0: reedClosed <= 1'b1;
			1: regWrite <= '{1'b1, 16'h0191, d};
			2: sdi12HotspotEnableCommand <= 1'b1;
			3: client.accessReq <= 1'b1;
			4: client[37:36] <= 2'b11;
			6: {client.paramWrite, client.value} <= {1'b1, 16'h0000, d};
			7: {client.keyChange, client.value} <= {1'b1, 16'h0000, d};
			default: client[37:36] <= 2'b00;
		endcase
		@(posedge ref_clk);
		reedClosed <= 1'b0;
		regWrite.wr <= 1'b0;
		sdi12HotspotEnableCommand <= 1'b0;
		client.accessReq <= 1'b0;
		client.paramWrite <= 1'b0;
		client.keyChange <= 1'b0;
		#1;
	endtask : fire
	task automatic rst(input logic opt);
		@(posedge ref_clk);
		powerOnEnableOption <= opt;
		rst_b <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Power-up beep stands for the first cycle after release only
		wait_cy(1);
		chk("beep", opt, beep);
		chk("netId", 32'h0000abcd, networkId);
		$display("test reset %0d done", opt);
	endtask : rst
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (3000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
	initial begin
		rst_b <= 1'b0;
		reedClosed <= 1'b0;
		regWrite <= '0;
		sdi12HotspotEnableCommand <= 1'b0;
		client <= '0;
		rst(1'b0);
		chk("regRead", 16'h0000, enableRegRead);
		for (int s = 0; s < 3; s++) begin
			fire(s, 16'h0001);
			chk("beep", 1, beep);
			wait_cy(Start);
			chk("avail", 1, hotspotAvailable);
			wait_cy(Idle - Start + 4);
			chk("radio", 0, radioEnable);
		end
		$display("test sources done");
		fire(1, 16'h0001);
		wait_cy(Start);
		fire(3, 16'h0000);
		chk("refused", 1, accessRefused);
		fire(4, 16'h0000);
		fire(3, 16'h0000);
		chk("grant", 1, accessGrant);
		fire(6, 16'h1234);
		chk("pgrant", 1, paramWriteGrant);
		fire(7, 16'h5a5a);
		fire(6, 16'h1234);
		chk("pgrant", 0, paramWriteGrant);
		fire(6, 16'h5a5a);
		chk("pgrant", 1, paramWriteGrant);
		wait_cy(Idle + 10);
		chk("radio", 1, radioEnable);
		fire(1, 16'h0002);
		chk("beep", 0, beep);
		chk("regRead", 16'h0002, enableRegRead);
		fire(5, 16'h0000);
		wait_cy(Idle - 4);
		chk("radio", 1, radioEnable);
		wait_cy(8);
		chk("radio", 0, radioEnable);
		$display("test session done");
		rst(1'b1);
		complete_run();
	end
endmodule : wireless_hotspot_enable_ctrl_tb
